// ---- logic/dpr_pkg.sv ----
/*
 Shared constants, types and helpers of the dual-port RAM port control.
 Assumes both ends and the carrier import this package.
*/
package dpr_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W      = 18;
	localparam int ADDR_W_128K = 17;
	localparam int ADDR_W_64K  = 16;
	localparam int DATA_W      = 36;
	localparam int LANES       = 4;
	localparam int LANE_W      = 9;

	// ------------------------------------------------------------
	// Addresses and reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 18'h3FFFF;
	localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 18'h3FFFE;
	localparam logic [ADDR_W-1:0] MASK_RST        = 18'h3FFFF;
	localparam logic [ADDR_W-1:0] CNT_RST         = 18'h00000;
	localparam logic [ADDR_W-1:0] CNT_STEP        = 18'h00001;
	localparam logic [LANES-1:0]  LANES_OFF_N     = 4'hF;
	localparam int                READ_LAT_CYC    = 1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ_LOAD  = 3'h0,
		OP_WRITE_LOAD = 3'h1,
		OP_READ_INC   = 3'h2,
		OP_WRITE_INC  = 3'h3,
		OP_LOAD_MASK  = 3'h4,
		OP_RDBK_CNT   = 3'h5,
		OP_RDBK_MASK  = 3'h6,
		OP_CLEAR_READ = 3'h7
	} dpr_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_ISSUE = 3'h2,
		ST_WAIT  = 3'h4
	} dpr_hst_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic dpr_at_max(
		input logic [ADDR_W-1:0] v,
		input logic [ADDR_W-1:0] mask
	);
		return (v & mask) == mask;
	endfunction

	function automatic logic [DATA_W-1:0] dpr_merge(
		input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w,
		input logic [LANES-1:0]  lanes_n
	);
		logic [DATA_W-1:0] r;
		r = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!lanes_n[i]) begin
				r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		return r;
	endfunction

endpackage

// ---- logic/dpr_if.sv ----
/*
 Pin bundle of one RAM port, device modport and host modport.
 Assumes one clock shared by both ends; two-way pins are split into in, out and enable signals.
*/
`timescale 1ns/1ps
interface dpr_if;
	import dpr_pkg::*;

	logic              chip_select_active_low;
	logic              chip_select_active_high;
	logic              rd_wr_sel;
	logic              out_enable_n;
	logic              address_load_strobe_n;
	logic              count_advance_n;
	logic              counter_clear_n;
	logic              counter_or_mask_select;
	logic              global_clear_n;
	logic [LANES-1:0]  byte_lane_enables_n;
	logic [ADDR_W-1:0] addr_in;
	logic [ADDR_W-1:0] addr_out;
	logic              addr_oe;
	logic [DATA_W-1:0] dq_in;
	logic [DATA_W-1:0] dq_out;
	logic              dq_oe;
	logic              mailbox_flag_n;
	logic              counter_wrap_flag_n;

	modport dev (
		input  chip_select_active_low, chip_select_active_high, rd_wr_sel,
		input  out_enable_n, address_load_strobe_n, count_advance_n,
		input  counter_clear_n, counter_or_mask_select, global_clear_n,
		input  byte_lane_enables_n, addr_in, dq_in,
		output addr_out, addr_oe, dq_out, dq_oe,
		output mailbox_flag_n, counter_wrap_flag_n
	);

	modport host (
		output chip_select_active_low, chip_select_active_high, rd_wr_sel,
		output out_enable_n, address_load_strobe_n, count_advance_n,
		output counter_clear_n, counter_or_mask_select, global_clear_n,
		output byte_lane_enables_n, addr_in, dq_in,
		input  addr_out, addr_oe, dq_out, dq_oe,
		input  mailbox_flag_n, counter_wrap_flag_n
	);

endinterface

// ---- logic/dpr_dev.sv ----
/*
 Device end: two port controllers, the shared array and the mailboxes.
 Assumes both port hosts run on clk and keep their own timing duties.
*/
`timescale 1ns/1ps
module dpr_port
	import dpr_pkg::*;
(
	input  logic              clk,
	input  logic              reset,
	input  logic              ce,
	dpr_if.dev                p,
	input  logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] acc_addr,
	output logic              acc_we,
	output logic              acc_re
);

	// ------------------------------------------------------------
	// Counter, mask and readback
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] cnt_ff;
	logic [ADDR_W-1:0] nxt_cnt;
	logic [ADDR_W-1:0] mask_ff;
	logic [ADDR_W-1:0] nxt_mask;
	logic [ADDR_W-1:0] base_ff;
	logic [ADDR_W-1:0] nxt_base;
	logic [ADDR_W-1:0] rbv_ff;
	logic [ADDR_W-1:0] nxt_rbv;
	logic              rb_ff;
	logic              nxt_rb;
	logic              wrap_n_ff;
	logic              nxt_wrap_n;
	logic              rdv_ff;
	logic              nxt_rdv;
	logic              sel;

	always_comb begin
		nxt_cnt    = cnt_ff;
		nxt_mask   = mask_ff;
		nxt_base   = base_ff;
		nxt_rbv    = rbv_ff;
		nxt_rb     = 1'b0;
		nxt_wrap_n = wrap_n_ff;
		if (!p.global_clear_n) begin
			nxt_cnt    = CNT_RST;
			nxt_base   = CNT_RST;
			nxt_mask   = MASK_RST;
			nxt_wrap_n = 1'b1;
		end else if (!p.counter_clear_n) begin
			// Access below uses the cleared value in this same cycle
			nxt_cnt    = CNT_RST;
			nxt_base   = CNT_RST;
			nxt_wrap_n = 1'b1;
		end else if (p.counter_or_mask_select) begin
			unique case ({p.address_load_strobe_n, p.count_advance_n})
				2'b00: begin
					nxt_cnt    = p.addr_in;
					nxt_base   = p.addr_in;
					nxt_wrap_n = 1'b1;
				end
				2'b10: begin
					if (dpr_at_max(cnt_ff, mask_ff)) begin
						nxt_cnt = base_ff;
					end else begin
						nxt_cnt = (cnt_ff & ~mask_ff)
							| ((cnt_ff + CNT_STEP) & mask_ff);
					end
					nxt_wrap_n = !dpr_at_max(nxt_cnt, mask_ff);
				end
				2'b01: begin
					nxt_rb  = 1'b1;
					nxt_rbv = cnt_ff;
				end
				2'b11: begin
				end
			endcase
		end else begin
			unique case ({p.address_load_strobe_n, p.count_advance_n})
				2'b00: begin
					nxt_mask = p.addr_in;
				end
				2'b01: begin
					nxt_rb  = 1'b1;
					nxt_rbv = mask_ff;
				end
				2'b10, 2'b11: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	// Only contiguous low-order masks give a clean wrap boundary
	assign sel      = !p.chip_select_active_low && p.chip_select_active_high;
	assign acc_addr = nxt_cnt;
	assign acc_re   = ce && p.global_clear_n && sel && p.rd_wr_sel;
	// Drivers still on when write arrives: spend the cycle releasing them
	assign acc_we   = ce && p.global_clear_n && sel && !p.rd_wr_sel
		&& !(rdv_ff && !p.out_enable_n);
	assign nxt_rdv  = acc_re;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_ff    <= CNT_RST;
			mask_ff   <= MASK_RST;
			base_ff   <= CNT_RST;
			rbv_ff    <= CNT_RST;
			rb_ff     <= 1'b0;
			wrap_n_ff <= 1'b1;
			rdv_ff    <= 1'b0;
		end else if (ce) begin
			cnt_ff    <= nxt_cnt;
			mask_ff   <= nxt_mask;
			base_ff   <= nxt_base;
			rbv_ff    <= nxt_rbv;
			rb_ff     <= nxt_rb;
			wrap_n_ff <= nxt_wrap_n;
			rdv_ff    <= nxt_rdv;
		end
	end

	// ------------------------------------------------------------
	// Pin outputs
	// ------------------------------------------------------------
	assign p.dq_out              = rd_data;
	assign p.dq_oe               = rdv_ff && !p.out_enable_n;
	assign p.addr_out            = rbv_ff;
	assign p.addr_oe             = rb_ff;
	assign p.counter_wrap_flag_n = wrap_n_ff;

endmodule

module dpr_dev
	import dpr_pkg::*;
(
	input  logic clk,
	input  logic reset,
	input  logic ce,
	dpr_if.dev   lp,
	dpr_if.dev   rp
);

	// ------------------------------------------------------------
	// Ports
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] l_addr;
	logic [ADDR_W-1:0] r_addr;
	logic              l_we;
	logic              l_re;
	logic              r_we;
	logic              r_re;
	logic [DATA_W-1:0] l_rd_ff;
	logic [DATA_W-1:0] r_rd_ff;
	logic [DATA_W-1:0] nxt_l_rd;
	logic [DATA_W-1:0] nxt_r_rd;

	// Full 256K-word depth; narrower parts use the low address bits
	logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

	dpr_port u_left (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.p        (lp),
		.rd_data  (l_rd_ff),
		.acc_addr (l_addr),
		.acc_we   (l_we),
		.acc_re   (l_re)
	);

	dpr_port u_right (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.p        (rp),
		.rd_data  (r_rd_ff),
		.acc_addr (r_addr),
		.acc_we   (r_we),
		.acc_re   (r_re)
	);

	// ------------------------------------------------------------
	// Array
	// ------------------------------------------------------------
	// A read in the cycle of the other port's write sees the old word
	always_comb begin
		nxt_l_rd = l_re ? mem[l_addr] : l_rd_ff;
		nxt_r_rd = r_re ? mem[r_addr] : r_rd_ff;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			l_rd_ff <= '0;
			r_rd_ff <= '0;
		end else if (ce) begin
			l_rd_ff <= nxt_l_rd;
			r_rd_ff <= nxt_r_rd;
		end
	end

	// Same-word writes from both ports in one cycle: right port wins
	always_ff @(posedge clk) begin
		if (l_we) begin
			mem[l_addr] <= dpr_merge(mem[l_addr], lp.dq_in,
				lp.byte_lane_enables_n);
		end
		if (r_we) begin
			mem[r_addr] <= dpr_merge(mem[r_addr], rp.dq_in,
				rp.byte_lane_enables_n);
		end
	end

	// ------------------------------------------------------------
	// Mailboxes
	// ------------------------------------------------------------
	logic lmb_ff;
	logic rmb_ff;
	logic nxt_lmb;
	logic nxt_rmb;
	logic r_set;
	logic r_clr;
	logic l_set;
	logic l_clr;

	always_comb begin
		r_set = l_we && (l_addr == MBOX_RIGHT_ADDR)
			&& !(&lp.byte_lane_enables_n);
		r_clr = r_re && (r_addr == MBOX_RIGHT_ADDR);
		l_set = r_we && (r_addr == MBOX_LEFT_ADDR)
			&& !(&rp.byte_lane_enables_n);
		l_clr = l_re && (l_addr == MBOX_LEFT_ADDR);
		// A set in the clearing cycle survives
		nxt_rmb = rp.global_clear_n && (r_set || (rmb_ff && !r_clr));
		nxt_lmb = lp.global_clear_n && (l_set || (lmb_ff && !l_clr));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lmb_ff <= 1'b0;
			rmb_ff <= 1'b0;
		end else if (ce) begin
			lmb_ff <= nxt_lmb;
			rmb_ff <= nxt_rmb;
		end
	end

	assign lp.mailbox_flag_n = !lmb_ff;
	assign rp.mailbox_flag_n = !rmb_ff;

endmodule

// ---- logic/dpr_host.sv ----
/*
 Host end of one RAM port: turns user commands into pin cycles.
 Assumes the device shares clk; one command in flight at a time.
*/
`timescale 1ns/1ps
module dpr_host
	import dpr_pkg::*;
(
	input  logic              clk,
	input  logic              reset,
	input  logic              ce,
	dpr_if.host               h,
	input  logic              cmd_valid,
	output logic              cmd_ready,
	input  dpr_op_t           cmd_op,
	input  logic [ADDR_W-1:0] cmd_addr,
	input  logic [DATA_W-1:0] cmd_data,
	input  logic [LANES-1:0]  cmd_lanes,
	output logic              rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output logic              mbox_flag,
	output logic              wrap_flag
);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	dpr_hst_t          st_ff, nxt_st;
	logic              sel_ff, nxt_sel;
	logic              rw_ff, nxt_rw;
	logic              oe_n_ff, nxt_oe_n;
	logic              ads_n_ff, nxt_ads_n;
	logic              cnt_n_ff, nxt_cnt_n;
	logic              clr_n_ff, nxt_clr_n;
	logic              cms_ff, nxt_cms;
	logic              aoe_ff, nxt_aoe;
	logic              doe_ff, nxt_doe;
	logic              wt_ff, nxt_wt;
	logic              rb_ff, nxt_rb;
	logic              rspv_ff, nxt_rspv;
	logic              gclr_n_ff;
	logic [LANES-1:0]  be_n_ff, nxt_be_n;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] dq_ff, nxt_dq;
	logic [DATA_W-1:0] rspd_ff, nxt_rspd;

	always_comb begin
		nxt_st    = st_ff;
		nxt_sel   = 1'b0;
		nxt_rw    = 1'b1;
		nxt_oe_n  = 1'b1;
		nxt_ads_n = 1'b1;
		nxt_cnt_n = 1'b1;
		nxt_clr_n = 1'b1;
		nxt_cms   = 1'b1;
		nxt_aoe   = 1'b0;
		nxt_doe   = 1'b0;
		nxt_be_n  = LANES_OFF_N;
		nxt_addr  = addr_ff;
		nxt_dq    = dq_ff;
		nxt_wt    = wt_ff;
		nxt_rb    = rb_ff;
		nxt_rspv  = 1'b0;
		nxt_rspd  = rspd_ff;
		unique case (st_ff)
			ST_IDLE: begin
				if (cmd_valid) begin
					nxt_st   = ST_ISSUE;
					nxt_addr = cmd_addr;
					nxt_dq   = cmd_data;
					nxt_aoe  = 1'b1;
					nxt_wt   = 1'b0;
					nxt_rb   = 1'b0;
					unique case (cmd_op)
						OP_READ_LOAD, OP_READ_INC, OP_CLEAR_READ: begin
							nxt_sel   = 1'b1;
							nxt_oe_n  = 1'b0;
							nxt_wt    = 1'b1;
							nxt_ads_n = (cmd_op != OP_READ_LOAD);
							nxt_cnt_n = (cmd_op == OP_CLEAR_READ);
							nxt_clr_n = (cmd_op != OP_CLEAR_READ);
						end
						OP_WRITE_LOAD, OP_WRITE_INC: begin
							// Output enable kept high so no dead cycle is lost
							nxt_sel   = 1'b1;
							nxt_rw    = 1'b0;
							nxt_doe   = 1'b1;
							nxt_be_n  = ~cmd_lanes;
							nxt_ads_n = (cmd_op == OP_WRITE_INC);
							nxt_cnt_n = 1'b0;
						end
						OP_LOAD_MASK: begin
							nxt_cms   = 1'b0;
							nxt_ads_n = 1'b0;
							nxt_cnt_n = 1'b0;
						end
						OP_RDBK_CNT, OP_RDBK_MASK: begin
							nxt_cms   = (cmd_op == OP_RDBK_CNT);
							nxt_ads_n = 1'b0;
							nxt_aoe   = 1'b0;
							nxt_wt    = 1'b1;
							nxt_rb    = 1'b1;
						end
					endcase
				end
			end
			ST_ISSUE: begin
				nxt_st   = wt_ff ? ST_WAIT : ST_IDLE;
				nxt_oe_n = !(wt_ff && !rb_ff);
			end
			ST_WAIT: begin
				// Device drives read data here; output enable is released at the next edge
				nxt_st   = ST_IDLE;
				nxt_rspv = 1'b1;
				nxt_rspd = rb_ff ? {{(DATA_W-ADDR_W){1'b0}}, h.addr_out}
					: h.dq_out;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff     <= ST_IDLE;
			sel_ff    <= 1'b0;
			rw_ff     <= 1'b1;
			oe_n_ff   <= 1'b1;
			ads_n_ff  <= 1'b1;
			cnt_n_ff  <= 1'b1;
			clr_n_ff  <= 1'b1;
			cms_ff    <= 1'b1;
			aoe_ff    <= 1'b0;
			doe_ff    <= 1'b0;
			be_n_ff   <= LANES_OFF_N;
			addr_ff   <= CNT_RST;
			dq_ff     <= '0;
			wt_ff     <= 1'b0;
			rb_ff     <= 1'b0;
			rspv_ff   <= 1'b0;
			rspd_ff   <= '0;
			gclr_n_ff <= 1'b0;
		end else if (ce) begin
			st_ff     <= nxt_st;
			sel_ff    <= nxt_sel;
			rw_ff     <= nxt_rw;
			oe_n_ff   <= nxt_oe_n;
			ads_n_ff  <= nxt_ads_n;
			cnt_n_ff  <= nxt_cnt_n;
			clr_n_ff  <= nxt_clr_n;
			cms_ff    <= nxt_cms;
			aoe_ff    <= nxt_aoe;
			doe_ff    <= nxt_doe;
			be_n_ff   <= nxt_be_n;
			addr_ff   <= nxt_addr;
			dq_ff     <= nxt_dq;
			wt_ff     <= nxt_wt;
			rb_ff     <= nxt_rb;
			rspv_ff   <= nxt_rspv;
			rspd_ff   <= nxt_rspd;
			gclr_n_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Pins and user side
	// ------------------------------------------------------------
	assign h.chip_select_active_low  = !sel_ff;
	assign h.chip_select_active_high = sel_ff;
	assign h.rd_wr_sel               = rw_ff;
	assign h.out_enable_n            = oe_n_ff;
	assign h.address_load_strobe_n   = ads_n_ff;
	assign h.count_advance_n         = cnt_n_ff;
	assign h.counter_clear_n         = clr_n_ff;
	assign h.counter_or_mask_select  = cms_ff;
	assign h.global_clear_n          = gclr_n_ff;
	assign h.byte_lane_enables_n     = be_n_ff;
	assign h.addr_in                 = addr_ff;
	assign h.dq_in                   = dq_ff;
	assign cmd_ready = ce && (st_ff == ST_IDLE);
	assign rsp_valid = rspv_ff;
	assign rsp_data  = rspd_ff;
	assign mbox_flag = !h.mailbox_flag_n;
	assign wrap_flag = !h.counter_wrap_flag_n;

endmodule

// ---- sim/dpr_chk_sva.sv ----
/*
 Assertions on the left port pins of the RAM port control.
 Assumes shared clk and reset; ce drops only while the host is idle.
*/
`timescale 1ns/1ps
module dpr_chk
	import dpr_pkg::*;
(
	input logic              clk,
	input logic              reset,
	input logic              chip_select_active_low,
	input logic              chip_select_active_high,
	input logic              rd_wr_sel,
	input logic              out_enable_n,
	input logic              address_load_strobe_n,
	input logic              count_advance_n,
	input logic              counter_clear_n,
	input logic              counter_or_mask_select,
	input logic              global_clear_n,
	input logic [ADDR_W-1:0] addr_in,
	input logic              addr_oe,
	input logic              dq_oe,
	input logic              mailbox_flag_n,
	input logic              counter_wrap_flag_n
);
	// --------
	// Decoded pin cycles
	// --------
	logic sel;
	logic rdbk;
	logic ld;
	logic inc;
	assign sel = !chip_select_active_low && chip_select_active_high
		&& global_clear_n;
	assign rdbk = !address_load_strobe_n && count_advance_n
		&& counter_clear_n && global_clear_n;
	assign ld = !address_load_strobe_n && !count_advance_n
		&& counter_or_mask_select;
	assign inc = address_load_strobe_n && !count_advance_n
		&& counter_or_mask_select && counter_clear_n && global_clear_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// --------
	// Properties
	// --------
	property p_rd_lat; sel && rd_wr_sel |=> dq_oe || out_enable_n; endproperty
	property p_desel; !sel |=> !dq_oe; endproperty
	property p_oe; out_enable_n |-> !dq_oe; endproperty
	property p_wr_noout; sel && !rd_wr_sel |=> !dq_oe; endproperty
	// Host keeps output enable off on writes so none becomes a no-op
	property p_wr_oe; sel && !rd_wr_sel |-> out_enable_n; endproperty
	property p_rdbk; rdbk |=> addr_oe; endproperty
	property p_no_rdbk; !rdbk |=> !addr_oe; endproperty
	property p_wrap_ld;
		ld || !counter_clear_n || !global_clear_n |=> counter_wrap_flag_n;
	endproperty
	property p_wrap_fall; $fell(counter_wrap_flag_n) |-> $past(inc); endproperty
	// Same-edge set from the right port would win; the bench avoids it
	property p_mbox_clr;
		sel && rd_wr_sel && ld && counter_clear_n
			&& addr_in == MBOX_LEFT_ADDR |=> mailbox_flag_n;
	endproperty

	a_rd_lat: assert property (p_rd_lat)
		else $error("read without data a cycle later");
	a_desel: assert property (p_desel)
		else $error("data driven after deselect");
	a_oe: assert property (p_oe)
		else $error("data driven with output enable high");
	a_wr_noout: assert property (p_wr_noout)
		else $error("data driven after write");
	a_wr_oe: assert property (p_wr_oe)
		else $error("write issued with output enable active");
	a_rdbk: assert property (p_rdbk)
		else $error("readback not shown on address lines");
	a_no_rdbk: assert property (p_no_rdbk)
		else $error("address lines driven outside readback");
	a_wrap_ld: assert property (p_wrap_ld)
		else $error("wrap flag low after load or clear");
	a_wrap_fall: assert property (p_wrap_fall)
		else $error("wrap flag fell without increment");
	a_mbox_clr: assert property (p_mbox_clr)
		else $error("mailbox flag not cleared by read");

	c_rdbk: cover property (rdbk ##1 addr_oe);
	c_wrap: cover property ($fell(counter_wrap_flag_n));
	c_mbox: cover property ($rose(mailbox_flag_n));
endmodule

// ---- sim/tb_dual_port_ram_port_control.sv ----
/*
 Self-checking bench: the device joined to a host on each port.
 Assumes the package, carrier and both design ends compile first.
*/
`timescale 1ns/1ps
`define CHK(what, exp, got) \
begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
	end \
end
module tb_dual_port_ram_port_control
	import dpr_pkg::*;
;
	typedef struct {
		dpr_op_t           op;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [LANES-1:0]  l;
		logic [DATA_W-1:0] exp;
		logic              wrap;
	} dpr_row_t;

	localparam logic [DATA_W-1:0] MRG = {9'h000, 9'h1FF, 9'h000, 9'h1FF};

	// --------
	// Ordinary cases on the left port, mask 3 gives a four-word block
	// --------
	dpr_row_t rows [20] = '{
		'{OP_WRITE_LOAD, 18'h10, 36'h111111111, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_LOAD, 18'h11, 36'h222222222, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_LOAD, 18'h12, 36'h333333333, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_LOAD, 18'h13, 36'h0, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_LOAD, 18'h13, 36'hFFFFFFFFF, 4'h5, 36'h0, 1'b0},
		'{OP_READ_LOAD, 18'h13, 36'h0, 4'hF, MRG, 1'b0},
		'{OP_LOAD_MASK, 18'h3, 36'h0, 4'hF, 36'h0, 1'b0},
		'{OP_RDBK_MASK, 18'h0, 36'h0, 4'hF, 36'h3, 1'b0},
		'{OP_READ_LOAD, 18'h10, 36'h0, 4'hF, 36'h111111111, 1'b0},
		'{OP_READ_INC, 18'h0, 36'h0, 4'hF, 36'h222222222, 1'b0},
		'{OP_READ_INC, 18'h0, 36'h0, 4'hF, 36'h333333333, 1'b0},
		'{OP_READ_INC, 18'h0, 36'h0, 4'hF, MRG, 1'b1},
		'{OP_READ_INC, 18'h0, 36'h0, 4'hF, 36'h111111111, 1'b0},
		'{OP_RDBK_CNT, 18'h0, 36'h0, 4'hF, 36'h10, 1'b0},
		'{OP_LOAD_MASK, 18'h3FFFF, 36'h0, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_LOAD, 18'h0, 36'h5A5A5A5A5, 4'hF, 36'h0, 1'b0},
		'{OP_WRITE_INC, 18'h0, 36'hC3C3C3C3C, 4'hF, 36'h0, 1'b0},
		'{OP_CLEAR_READ, 18'h7, 36'h0, 4'hF, 36'h5A5A5A5A5, 1'b0},
		'{OP_RDBK_CNT, 18'h0, 36'h0, 4'hF, 36'h0, 1'b0},
		'{OP_READ_LOAD, 18'h1, 36'h0, 4'hF, 36'hC3C3C3C3C, 1'b0}
	};

	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic              ce = 1'b1;
	logic              cv [2] = '{1'b0, 1'b0};
	dpr_op_t           cop [2] = '{OP_READ_LOAD, OP_READ_LOAD};
	logic [ADDR_W-1:0] ca [2] = '{18'h0, 18'h0};
	logic [DATA_W-1:0] cd [2] = '{36'h0, 36'h0};
	logic [LANES-1:0]  cl [2] = '{4'hF, 4'hF};
	logic              rdy [2];
	logic              rv [2];
	logic [DATA_W-1:0] rd [2];
	logic              mf [2];
	logic              wf [2];
	logic [DATA_W-1:0] v;
	int                failures = 0;
	int                cmp_count = 0;
	int                cyc = 0;

	dpr_if pif [2] ();

	dpr_dev i_dpr_dev (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.lp    (pif[0]),
		.rp    (pif[1])
	);

	for (genvar g = 0; g < 2; g++) begin : g_host
		dpr_host i_dpr_host (
			.clk       (clk),
			.reset     (reset),
			.ce        (ce),
			.h         (pif[g]),
			.cmd_valid (cv[g]),
			.cmd_ready (rdy[g]),
			.cmd_op    (cop[g]),
			.cmd_addr  (ca[g]),
			.cmd_data  (cd[g]),
			.cmd_lanes (cl[g]),
			.rsp_valid (rv[g]),
			.rsp_data  (rd[g]),
			.mbox_flag (mf[g]),
			.wrap_flag (wf[g])
		);
	end

	dpr_chk i_dpr_chk (
		.clk(clk),
		.reset(reset),
		.chip_select_active_low(pif[0].chip_select_active_low),
		.chip_select_active_high(pif[0].chip_select_active_high),
		.rd_wr_sel(pif[0].rd_wr_sel),
		.out_enable_n(pif[0].out_enable_n),
		.address_load_strobe_n(pif[0].address_load_strobe_n),
		.count_advance_n(pif[0].count_advance_n),
		.counter_clear_n(pif[0].counter_clear_n),
		.counter_or_mask_select(pif[0].counter_or_mask_select),
		.global_clear_n(pif[0].global_clear_n),
		.addr_in(pif[0].addr_in),
		.addr_oe(pif[0].addr_oe),
		.dq_oe(pif[0].dq_oe),
		.mailbox_flag_n(pif[0].mailbox_flag_n),
		.counter_wrap_flag_n(pif[0].counter_wrap_flag_n)
	);

	initial begin
		forever #4 clk = ~clk;
	end

	// Run is about 100 cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			end_of_test();
		end
	end

	// --------
	// Command helpers, all called at the falling edge
	// --------
	function automatic logic rdop(input dpr_op_t op);
		return !(op inside {OP_WRITE_LOAD, OP_WRITE_INC, OP_LOAD_MASK});
	endfunction

	task automatic put(input int s, input dpr_op_t op,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [LANES-1:0] l);
		cv[s] = 1'b1;
		cop[s] = op;
		ca[s] = a;
		cd[s] = d;
		cl[s] = l;
	endtask

	task automatic get(input int s, output logic [DATA_W-1:0] r);
		int n;
		n = 0;
		while (rv[s] !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		r = (rv[s] === 1'b1) ? rd[s] : 'x;
	endtask

	// Drops both requests after the taking edge so none is taken twice
	task automatic fin(input int s, input logic rdf,
		output logic [DATA_W-1:0] r);
		int n;
		n = 0;
		while (rdy[s] !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		// A request never taken is a hang, count it here
		if (rdy[s] !== 1'b1) begin
			failures++;
		end
		@(negedge clk);
		cv[0] = 1'b0;
		cv[1] = 1'b0;
		@(negedge clk);
		r = 'x;
		if (rdf) begin
			get(s, r);
		end
	endtask

	task automatic do_op(input int s, input dpr_op_t op,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [LANES-1:0] l, output logic [DATA_W-1:0] r);
		put(s, op, a, d, l);
		fin(s, rdop(op), r);
	endtask

	task automatic end_of_test();
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		foreach (rows[i]) begin
			do_op(0, rows[i].op, rows[i].a, rows[i].d, rows[i].l, v);
			if (rdop(rows[i].op)) `CHK("rsp_data", rows[i].exp, v)
			`CHK("wrap_flag", rows[i].wrap, wf[0])
		end
		// --------
		// Mailboxes, a lane-less write sets nothing
		// --------
		do_op(0, OP_WRITE_LOAD, MBOX_RIGHT_ADDR, 36'h1, 4'h1, v);
		`CHK("right mbox set", 1'b1, mf[1])
		`CHK("left mbox idle", 1'b0, mf[0])
		do_op(1, OP_READ_LOAD, MBOX_RIGHT_ADDR, 36'h0, 4'hF, v);
		`CHK("right mbox clear", 1'b0, mf[1])
		do_op(1, OP_WRITE_LOAD, MBOX_LEFT_ADDR, 36'h2, 4'h0, v);
		`CHK("no lane no flag", 1'b0, mf[0])
		do_op(1, OP_WRITE_LOAD, MBOX_LEFT_ADDR, 36'h2, 4'h8, v);
		`CHK("left mbox set", 1'b1, mf[0])
		do_op(0, OP_READ_LOAD, MBOX_LEFT_ADDR, 36'h0, 4'hF, v);
		`CHK("left mbox clear", 1'b0, mf[0])
		// Set and clear of one flag at one edge: the set survives
		put(0, OP_WRITE_LOAD, MBOX_RIGHT_ADDR, 36'h3, 4'hF);
		put(1, OP_READ_LOAD, MBOX_RIGHT_ADDR, 36'h0, 4'hF);
		fin(1, 1'b1, v);
		`CHK("set beats clear", 1'b1, mf[1])
		// --------
		// Same word across ports: same cycle old, one later new
		// --------
		do_op(0, OP_WRITE_LOAD, 18'h20, 36'hABCDEF012, 4'hF, v);
		put(0, OP_WRITE_LOAD, 18'h20, 36'h13579BDF0, 4'hF);
		put(1, OP_READ_LOAD, 18'h20, 36'h0, 4'hF);
		fin(0, 1'b0, v);
		get(1, v);
		`CHK("same cycle read", 36'hABCDEF012, v)
		put(0, OP_WRITE_LOAD, 18'h20, 36'h2468ACE13, 4'hF);
		@(negedge clk);
		cv[0] = 1'b0;
		put(1, OP_READ_LOAD, 18'h20, 36'h0, 4'hF);
		fin(1, 1'b1, v);
		`CHK("later read", 36'h2468ACE13, v)
		// --------
		// Clock enable low: request offered but nothing moves
		// --------
		ce = 1'b0;
		put(0, OP_READ_LOAD, 18'h20, 36'h0, 4'hF);
		repeat (3) @(negedge clk);
		`CHK("frozen ready", 1'b0, rdy[0])
		`CHK("frozen rsp", 1'b0, rv[0])
		ce = 1'b1;
		fin(0, 1'b1, v);
		`CHK("read after freeze", 36'h2468ACE13, v)
		// --------
		// Reset in mid-run restores mask and flags
		// --------
		do_op(0, OP_WRITE_LOAD, MBOX_RIGHT_ADDR, 36'h1, 4'hF, v);
		do_op(0, OP_LOAD_MASK, 18'h7, 36'h0, 4'hF, v);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		`CHK("mbox after reset", 1'b0, mf[1])
		do_op(0, OP_RDBK_MASK, 18'h0, 36'h0, 4'hF, v);
		`CHK("mask after reset", 36'h3FFFF, v)
		end_of_test();
	end
endmodule
